// *** logic/gtc_timer.v ***
// Purpose: Gated 16-bit up timer/counter with prescaler and overflow flag
// Assumes: One clock; instr_tick marks instruction cycles; all inputs except the external count and crystal inputs synchronous to clk
// Notes:   Control and status bits are plain ports; the crystal cell sits outside
//
// Summary of operation
// - Internal source advances the count once per prescaled group of instruction cycles.
// - Counter mode advances on each rising external edge, after prescaling.
// - First rising external edge counts only after a falling edge was seen.
// - Prescaler divides the input by 1, 2, 4 or 8 per select field.
// - Prescaler is hidden from software and cleared on any count byte write.
// - Writing a count byte immediately replaces that byte of the counter.
// - Source select 0 uses instruction clock; 1 uses the external input.
// - Prescale code 00 divides by 1, 01 by 2, 10 by 4, 11 by 8.
// - Oscillator enable starts the crystal oscillator, which keeps running in sleep.
// - Crystal clocks the counter only with internal or low-power system oscillator.
// - Crystal enabled forces shared pin direction bits to 1, data bits read 0.
// - Sync disable counts the raw input, also in sleep, overflow can wake.
// - Changing sync mode may lose one increment or add one spurious increment.
// - Count byte reads return valid values even with an asynchronous clock.
// - Gate comes from the gate pin or comparator two, chosen by software.
// - Gate source affects counting only while gate enable is set.
// - With timer on, gate enable set counts only while the gate is active.
// - Gate invert picks active-high or active-low sense for either source.
// - Count wraps FFFFh to 0000h and each wrap sets the overflow flag.
// - Interrupt requested only with overflow, peripheral and global enables all set.
// - Overflow flag stays set until software clears it.
// - In sleep only asynchronous counter mode runs; wake needs on and both enables.
// - Overflow wake resumes the core; with global enable it vectors to 0004h.
`include "gtc_timer_map.vh"
`timescale 1ns/1ps
`default_nettype none

module gtc_timer (
    input  wire                     clk,
    input  wire                     reset_n,
    input  wire                     instr_tick,
    input  wire                     external_count_input,
    input  wire                     crystal_clk_in,
    input  wire                     osc_source_ok,
    input  wire                     sleep_mode,
    input  wire                     timer_on,
    input  wire                     clock_source_select,
    input  wire                     sync_disable,
    input  wire [`GTC_PS_W-1:0]     prescale_select,
    input  wire                     crystal_osc_enable,
    input  wire                     gate_enable,
    input  wire                     gate_invert,
    input  wire                     gate_source_select,
    input  wire                     gate_pin,
    input  wire                     comparator_two_output,
    input  wire                     count_low_wr,
    input  wire                     count_high_wr,
    input  wire [`GTC_BYTE_W-1:0]   write_data,
    input  wire                     overflow_flag_clear,
    input  wire                     overflow_irq_enable,
    input  wire                     peripheral_irq_enable,
    input  wire                     global_irq_enable,
    input  wire [`GTC_PIN_W-1:0]    port_dir_in,
    input  wire [`GTC_PIN_W-1:0]    port_data_in,
    output reg  [`GTC_BYTE_W-1:0]   count_low_byte_q,
    output reg  [`GTC_BYTE_W-1:0]   count_high_byte_q,
    output reg                      overflow_flag_q,
    output reg                      irq_request_q,
    output reg                      wake_request_q,
    output reg  [`GTC_VEC_W-1:0]    vector_address_q,
    output reg                      crystal_run_q,
    output reg  [`GTC_PIN_W-1:0]    port_dir_read_q,
    output reg  [`GTC_PIN_W-1:0]    port_data_read_q
);

    // ------------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------------
    function [`GTC_PRE_W-1:0] pre_mask;
        input [`GTC_PS_W-1:0] sel;
        begin
            case (sel)
                `GTC_PS_DIV1: pre_mask = `GTC_MASK_DIV1;
                `GTC_PS_DIV2: pre_mask = `GTC_MASK_DIV2;
                `GTC_PS_DIV4: pre_mask = `GTC_MASK_DIV4;
                `GTC_PS_DIV8: pre_mask = `GTC_MASK_DIV8;
                default:      pre_mask = `GTC_MASK_DIV1;
            endcase
        end
    endfunction

    // Invert set means active high, clear means active low
    function gate_active;
        input src;
        input inv;
        begin
            gate_active = inv ? src : ~src;
        end
    endfunction

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    reg  [`GTC_CNT_W-1:0]  count_q;
    reg  [`GTC_CNT_W-1:0]  count_d;
    reg  [`GTC_PRE_W-1:0]  pre_q;
    reg  [`GTC_PRE_W-1:0]  pre_d;
    reg                    sync1_q;
    reg                    sync2_q;
    reg                    sync3_q;
    reg                    raw1_q;
    reg                    raw2_q;
    reg                    armed_q;
    reg                    armed_d;
    reg                    overflow_d;
    reg                    in_tick;
    reg                    count_tick;
    reg                    wrap;

    wire                   crystal_used;
    wire                   ext_source;
    wire                   ext_cur;
    wire                   ext_prev;
    wire                   ext_rise;
    wire                   ext_fall;
    wire                   gate_src;
    wire                   count_enable;
    wire                   sleep_block;
    wire                   irq_chain;

    // ------------------------------------------------------------------------
    // Clock source and edge detection
    // ------------------------------------------------------------------------
    assign crystal_used = crystal_osc_enable & osc_source_ok;
    assign ext_source   = crystal_used ? crystal_clk_in : external_count_input;

    // Two stages before the sync edge detector; stage one feeds stage two only
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end else begin
            sync1_q <= ext_source;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // Unsynchronized path: a single capture, so it reacts one cycle sooner
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            raw1_q <= 1'b0;
            raw2_q <= 1'b0;
        end else begin
            raw1_q <= ext_source;
            raw2_q <= raw1_q;
        end
    end

    // Different path lengths mean a mode switch can drop or add one edge
    assign ext_cur  = sync_disable ? raw1_q : sync2_q;
    assign ext_prev = sync_disable ? raw2_q : sync3_q;
    assign ext_rise = ext_cur & ~ext_prev;
    assign ext_fall = ~ext_cur & ext_prev;

    // ------------------------------------------------------------------------
    // Gate and enable
    // ------------------------------------------------------------------------
    assign gate_src     = gate_source_select ? comparator_two_output : gate_pin;
    assign count_enable = timer_on &
                          (~gate_enable | gate_active(gate_src, gate_invert));
    // Only the unsynchronized external path keeps running in sleep
    assign sleep_block  = sleep_mode & ~(clock_source_select & sync_disable);

    // ------------------------------------------------------------------------
    // Falling-edge arming for counter mode
    // ------------------------------------------------------------------------
    always @* begin
        armed_d = armed_q;
        if (!timer_on || !clock_source_select) begin
            armed_d = 1'b0;
        end else if (ext_fall) begin
            armed_d = 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Prescaler and counter
    // ------------------------------------------------------------------------
    always @* begin
        in_tick    = 1'b0;
        count_tick = 1'b0;
        wrap       = 1'b0;
        pre_d      = pre_q;
        count_d    = count_q;
        if (clock_source_select) begin
            in_tick = ext_rise & armed_q;
        end else begin
            in_tick = instr_tick;
        end
        if (count_enable && !sleep_block && in_tick) begin
            if ((pre_q & pre_mask(prescale_select)) == pre_mask(prescale_select)) begin
                pre_d      = `GTC_PRE_RST;
                count_tick = 1'b1;
            end else begin
                pre_d = pre_q + `GTC_PRE_ONE;
            end
        end
        if (count_tick) begin
            wrap    = (count_q == `GTC_CNT_MAX);
            count_d = count_q + `GTC_CNT_ONE;
        end
        // A write wins over a coinciding increment
        if (count_low_wr || count_high_wr) begin
            pre_d = `GTC_PRE_RST;
            wrap  = 1'b0;
            count_d = count_q;
        end
        if (count_low_wr) begin
            count_d[`GTC_LO_MSB:0] = write_data;
        end
        if (count_high_wr) begin
            count_d[`GTC_HI_MSB:`GTC_HI_LSB] = write_data;
        end
    end

    // ------------------------------------------------------------------------
    // Overflow flag and requests
    // ------------------------------------------------------------------------
    always @* begin
        overflow_d = overflow_flag_q;
        if (overflow_flag_clear) begin
            overflow_d = 1'b0;
        end
        if (wrap) begin
            overflow_d = 1'b1;
        end
    end

    assign irq_chain = overflow_flag_q & overflow_irq_enable & peripheral_irq_enable;

    // ------------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q         <= `GTC_CNT_RST;
            pre_q           <= `GTC_PRE_RST;
            armed_q         <= 1'b0;
            overflow_flag_q <= 1'b0;
        end else begin
            count_q         <= count_d;
            pre_q           <= pre_d;
            armed_q         <= armed_d;
            overflow_flag_q <= overflow_d;
        end
    end

    // ------------------------------------------------------------------------
    // Registered count outputs
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_low_byte_q  <= `GTC_BYTE_RST;
            count_high_byte_q <= `GTC_BYTE_RST;
        end else begin
            // Whole word registered in one edge, so both bytes are coherent
            count_low_byte_q  <= count_d[`GTC_LO_MSB:0];
            count_high_byte_q <= count_d[`GTC_HI_MSB:`GTC_HI_LSB];
        end
    end

    // ------------------------------------------------------------------------
    // Registered requests
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_request_q     <= 1'b0;
            wake_request_q    <= 1'b0;
            vector_address_q  <= `GTC_VEC_RST;
        end else begin
            irq_request_q     <= irq_chain & global_irq_enable;
            // Wake ignores the global enable; the irq request and the vector need it
            wake_request_q    <= irq_chain & timer_on & sleep_mode;
            vector_address_q  <= (irq_chain & global_irq_enable) ? `GTC_VECTOR : `GTC_VEC_RST;
        end
    end

    // ------------------------------------------------------------------------
    // Crystal status and shared pin readback
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            crystal_run_q     <= 1'b0;
            port_dir_read_q   <= `GTC_PIN_ONES;
            port_data_read_q  <= `GTC_PIN_ZEROS;
        end else begin
            crystal_run_q     <= crystal_osc_enable;
            port_dir_read_q   <= crystal_osc_enable ? `GTC_PIN_ONES : port_dir_in;
            port_data_read_q  <= crystal_osc_enable ? `GTC_PIN_ZEROS : port_data_in;
        end
    end

endmodule // gtc_timer

`default_nettype wire

// *** logic/gtc_timer_map.vh ***
// Purpose: Named constants for the gated 16-bit timer/counter
// Assumes: Included by gtc_timer.v only
// Notes:   Definitions only
`ifndef GTC_TIMER_MAP_VH
`define GTC_TIMER_MAP_VH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define GTC_CNT_W        16
`define GTC_BYTE_W       8
`define GTC_PRE_W        3
`define GTC_PS_W         2
`define GTC_PIN_W        2
`define GTC_VEC_W        16

// ----------------------------------------------------------------------------
// Prescale select encodings
// ----------------------------------------------------------------------------
`define GTC_PS_DIV1      2'h0
`define GTC_PS_DIV2      2'h1
`define GTC_PS_DIV4      2'h2
`define GTC_PS_DIV8      2'h3

// ----------------------------------------------------------------------------
// Prescaler terminal masks
// ----------------------------------------------------------------------------
`define GTC_MASK_DIV1    3'h0
`define GTC_MASK_DIV2    3'h1
`define GTC_MASK_DIV4    3'h3
`define GTC_MASK_DIV8    3'h7

// ----------------------------------------------------------------------------
// Values
// ----------------------------------------------------------------------------
`define GTC_CNT_MAX      16'hFFFF
`define GTC_CNT_RST      16'h0000
`define GTC_CNT_ONE      16'h0001
`define GTC_PRE_RST      3'h0
`define GTC_PRE_ONE      3'h1
`define GTC_VECTOR       16'h0004
`define GTC_VEC_RST      16'h0000
`define GTC_BYTE_RST     8'h00
`define GTC_PIN_ONES     2'h3
`define GTC_PIN_ZEROS    2'h0
`define GTC_LO_MSB       7
`define GTC_HI_LSB       8
`define GTC_HI_MSB       15

`endif

// *** testbench/gtc_ext_src_model.sv ***
// Purpose: External count pin and crystal clock source
// Assumes: Bench calls pulse from its own process
// Notes:   Both lines idle low between bursts
`timescale 1ns/1ps
`default_nettype none
module gtc_ext_src_model (
    input  wire logic clk,
    output var  logic ext_level,
    output var  logic xtal_level
);
    initial begin
        ext_level  = 1'b0;
        xtal_level = 1'b0;
    end
    // At least four clocks per level so the synchronizer never misses an edge
    task automatic pulse(input int n, input bit on_xtal);
        repeat (n) begin
            @(negedge clk) {xtal_level, ext_level} = on_xtal ? 2'b10 : 2'b01;
            repeat (4) @(negedge clk);
            {xtal_level, ext_level} = 2'b00;
            repeat (4) @(negedge clk);
        end
    endtask
endmodule // gtc_ext_src_model
`default_nettype wire

// *** testbench/gtc_timer_sva.sv ***
// Purpose: Port-level checks for gtc_timer
// Assumes: One clock, async active-low reset
// Notes:   Bound to every gtc_timer instance
`timescale 1ns/1ps
`default_nettype none
module gtc_timer_sva (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       instr_tick,
    input wire logic       timer_on,
    input wire logic       clock_source_select,
    input wire logic       sleep_mode,
    input wire logic       gate_enable,
    input wire logic [1:0] prescale_select,
    input wire logic       count_low_wr,
    input wire logic       count_high_wr,
    input wire logic [7:0] write_data,
    input wire logic       overflow_flag_clear,
    input wire logic       overflow_irq_enable,
    input wire logic       peripheral_irq_enable,
    input wire logic       global_irq_enable,
    input wire logic       crystal_osc_enable,
    input wire logic [7:0] count_low_byte_q,
    input wire logic [7:0] count_high_byte_q,
    input wire logic       overflow_flag_q,
    input wire logic       irq_request_q,
    input wire logic [1:0] port_dir_read_q,
    input wire logic [1:0] port_data_read_q
);
    wire logic [15:0] cnt = {count_high_byte_q, count_low_byte_q};
    wire logic        no_wr = !count_low_wr && !count_high_wr;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_write_low_byte: assert property (count_low_wr |=> count_low_byte_q == $past(write_data))
        else $error("low byte write lost");
    a_write_high_byte: assert property (count_high_wr |=> count_high_byte_q == $past(write_data))
        else $error("high byte write lost");
    a_off_holds_count: assert property (!timer_on && no_wr |=> $stable(cnt))
        else $error("count moved while off");
    a_tick_div_one: assert property (timer_on && !clock_source_select && !gate_enable && !sleep_mode
        && prescale_select == 2'h0 && instr_tick && no_wr |=> cnt == $past(cnt) + 16'h0001)
        else $error("internal tick not counted");
    a_wrap_sets_flag: assert property (cnt == 16'h0000 && $past(cnt) == 16'hFFFF && $past(no_wr)
        |-> overflow_flag_q) else $error("wrap without flag");
    a_flag_stays_set: assert property (overflow_flag_q && !overflow_flag_clear |=> overflow_flag_q)
        else $error("flag dropped");
    a_irq_all_enables: assert property (irq_request_q == $past(overflow_flag_q && overflow_irq_enable
        && peripheral_irq_enable && global_irq_enable)) else $error("irq request wrong");
    a_crystal_pin_read: assert property (crystal_osc_enable |=> port_dir_read_q == 2'h3
        && port_data_read_q == 2'h0) else $error("shared pins not forced");
    c_wrap: cover property ($rose(overflow_flag_q));
    c_irq: cover property ($rose(irq_request_q));
    c_crystal: cover property ($rose(crystal_osc_enable));
endmodule // gtc_timer_sva
bind gtc_timer gtc_timer_sva u_sva (.clk, .reset_n, .instr_tick, .timer_on, .clock_source_select, .sleep_mode,
    .gate_enable, .prescale_select, .count_low_wr, .count_high_wr, .write_data, .overflow_flag_clear,
    .overflow_irq_enable, .peripheral_irq_enable, .global_irq_enable, .crystal_osc_enable, .count_low_byte_q,
    .count_high_byte_q, .overflow_flag_q, .irq_request_q, .port_dir_read_q, .port_data_read_q);
`default_nettype wire

// *** testbench/tb_top.sv ***
// Purpose: Directed self-checking bench for gtc_timer
// Assumes: Inputs change on the falling clock edge
// Notes:   Pin and crystal edges both come from the source model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, reset_n, instr_tick, osc_source_ok, sleep_mode, timer_on, clock_source_select, sync_disable;
    logic crystal_osc_enable, gate_enable, gate_invert, gate_source_select, gate_pin, comparator_two_output;
    logic count_low_wr, count_high_wr, overflow_flag_clear, overflow_irq_enable, peripheral_irq_enable;
    logic global_irq_enable, ext_level, xtal_level, overflow_flag_q, irq_request_q, wake_request_q, crystal_run_q;
    logic [1:0]  prescale_select, port_dir_in, port_data_in, port_dir_read_q, port_data_read_q;
    logic [7:0]  write_data, count_low_byte_q, count_high_byte_q;
    logic [15:0] vector_address_q;
    int          bad_count, checked;
    wire  [15:0] cnt = {count_high_byte_q, count_low_byte_q};
    gtc_ext_src_model ext (.clk, .ext_level, .xtal_level);
    gtc_timer DUT (.clk, .reset_n, .instr_tick, .external_count_input(ext_level), .crystal_clk_in(xtal_level),
        .osc_source_ok, .sleep_mode, .timer_on, .clock_source_select, .sync_disable, .prescale_select,
        .crystal_osc_enable, .gate_enable, .gate_invert, .gate_source_select, .gate_pin, .comparator_two_output,
        .count_low_wr, .count_high_wr, .write_data, .overflow_flag_clear, .overflow_irq_enable,
        .peripheral_irq_enable, .global_irq_enable, .port_dir_in, .port_data_in, .count_low_byte_q,
        .count_high_byte_q, .overflow_flag_q, .irq_request_q, .wake_request_q, .vector_address_q,
        .crystal_run_q, .port_dir_read_q, .port_data_read_q);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t %s got %h want %h", $time, msg, seen, exp);
        end
    endtask
    // Trailing two cycles let registered outputs settle before a check
    task automatic ticks(input int n);
        repeat (n) begin
            @(negedge clk) instr_tick = 1'b1;
            @(negedge clk) instr_tick = 1'b0;
        end
        repeat (2) @(negedge clk);
    endtask
    task automatic wr16(input logic [15:0] v);
        @(negedge clk) {count_low_wr, write_data} = {1'b1, v[7:0]};
        @(negedge clk) {count_low_wr, count_high_wr, write_data} = {2'b01, v[15:8]};
        @(negedge clk) count_high_wr = 1'b0;
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_prescale();
        int n;
        for (int ps = 0; ps < 4; ps++) begin
            n = 1 << ps;
            @(negedge clk) {timer_on, prescale_select} = {1'b1, ps[1:0]};
            ticks(n - 1);
            wr16(16'h0000);
            ticks(2 * n - 1);
            chk(cnt, 16'h0001, "prescale");
        end
        $display("test prescale done");
    endtask
    task automatic t_gate();
        wr16(16'h0000);
        @(negedge clk) {prescale_select, gate_enable, gate_invert, gate_source_select, gate_pin} = 6'b001100;
        ticks(3);
        chk(cnt, 16'h0000, "gate low");
        @(negedge clk) gate_pin = 1'b1;
        ticks(2);
        chk(cnt, 16'h0002, "gate high");
        @(negedge clk) gate_invert = 1'b0;
        ticks(2);
        chk(cnt, 16'h0002, "gate inverted");
        @(negedge clk) gate_source_select = 1'b1;
        ticks(1);
        chk(cnt, 16'h0003, "comparator gate");
        @(negedge clk) {gate_enable, comparator_two_output} = 2'b01;
        ticks(1);
        chk(cnt, 16'h0004, "gate off");
        @(negedge clk) timer_on = 1'b0;
        ticks(2);
        chk(cnt, 16'h0004, "timer off");
        $display("test gate done");
    endtask
    task automatic t_overflow();
        wr16(16'h0000);
        @(negedge clk) overflow_flag_clear = 1'b1;
        @(negedge clk) {overflow_flag_clear, overflow_irq_enable, peripheral_irq_enable} = 3'b011;
        wr16(16'hFFFF);
        @(negedge clk) timer_on = 1'b1;
        ticks(1);
        chk(cnt, 16'h0000, "wrap");
        chk(16'(overflow_flag_q), 16'h0001, "flag");
        chk(16'(irq_request_q), 16'h0000, "irq no global");
        chk(vector_address_q, 16'h0000, "vector no global");
        chk(16'(wake_request_q), 16'h0000, "no wake while awake");
        @(negedge clk) global_irq_enable = 1'b1;
        ticks(1);
        chk(16'(irq_request_q), 16'h0001, "irq");
        chk(vector_address_q, 16'h0004, "vector");
        chk(16'(overflow_flag_q), 16'h0001, "flag held");
        @(negedge clk) overflow_flag_clear = 1'b1;
        @(negedge clk) overflow_flag_clear = 1'b0;
        ticks(0);
        chk(16'({overflow_flag_q, irq_request_q}), 16'h0000, "clear");
        @(negedge clk) {global_irq_enable, timer_on} = 2'b00;
        $display("test overflow done");
    endtask
    task automatic t_crystal();
        @(negedge clk) {port_dir_in, port_data_in, osc_source_ok, crystal_osc_enable} = 6'b001111;
        ticks(0);
        chk(16'({port_dir_read_q, port_data_read_q}), 16'h000C, "pins forced");
        chk(16'(crystal_run_q), 16'h0001, "crystal run");
        @(negedge clk) {osc_source_ok, crystal_osc_enable} = 2'b00;
        ticks(0);
        chk(16'({port_dir_read_q, port_data_read_q}), 16'h0003, "pins free");
        $display("test crystal done");
    endtask
    task automatic t_external();
        @(negedge clk) {clock_source_select, sync_disable, sleep_mode} = 3'b100;
        wr16(16'h0000);
        @(negedge clk) timer_on = 1'b1;
        ext.pulse(3, 1'b0);
        chk(cnt, 16'h0002, "sync count");
        @(negedge clk) {timer_on, sync_disable, sleep_mode} = 3'b011;
        wr16(16'hFFFE);
        @(negedge clk) timer_on = 1'b1;
        ext.pulse(3, 1'b0);
        chk(cnt, 16'h0000, "async in sleep");
        chk(16'(wake_request_q), 16'h0001, "wake in sleep");
        @(negedge clk) clock_source_select = 1'b0;
        ticks(2);
        chk(cnt, 16'h0000, "internal in sleep");
        @(negedge clk) {timer_on, clock_source_select, sleep_mode, osc_source_ok, crystal_osc_enable} = 5'b01011;
        repeat (8) @(negedge clk);
        @(negedge clk) timer_on = 1'b1;
        ext.pulse(3, 1'b0);
        chk(cnt, 16'h0000, "pin ignored with crystal");
        ext.pulse(3, 1'b1);
        chk(cnt, 16'h0002, "crystal count");
        @(negedge clk) {timer_on, osc_source_ok, crystal_osc_enable} = 3'b000;
        $display("test external done");
    endtask
    task automatic report_and_stop();
        $display("Comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        {reset_n, instr_tick, osc_source_ok, sleep_mode, timer_on, clock_source_select, sync_disable} = '0;
        {crystal_osc_enable, gate_enable, gate_invert, gate_source_select, gate_pin, comparator_two_output} = '0;
        {count_low_wr, count_high_wr, overflow_flag_clear, overflow_irq_enable, peripheral_irq_enable} = '0;
        {global_irq_enable, prescale_select, port_dir_in, port_data_in, write_data} = '0;
        bad_count = 0;
        checked = 0;
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        t_prescale();
        t_gate();
        t_overflow();
        t_crystal();
        t_external();
        report_and_stop();
    end
    // Whole run is well under a thousand cycles
    initial begin
        #50000;
        bad_count++;
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
